// ### common/aioc_map.svh
// register offsets, field positions, reset values and timing counts
`ifndef AIOC_MAP_SVH
`define AIOC_MAP_SVH
`define AIOC_OFS_CTRL       8'h00
`define AIOC_OFS_IN1_VALUE  8'h01
`define AIOC_OFS_IN2_VALUE  8'h02
`define AIOC_OFS_OUT_VALUE  8'h03
`define AIOC_OFS_IN1_AVG    8'h04
`define AIOC_OFS_IN2_AVG    8'h05
`define AIOC_OFS_ERR        8'h06
`define AIOC_OFS_ERR_MASK   8'h07
`define AIOC_OFS_ID         8'h08
`define AIOC_OFS_CONTROL    8'h09
`define AIOC_BIT_IN1_MODE   0
`define AIOC_BIT_IN2_MODE   1
`define AIOC_BIT_OUT_MODE   2
`define AIOC_BIT_HOLD_CAN   6
`define AIOC_BIT_IN1_DIS    7
`define AIOC_BIT_IN2_DIS    8
`define AIOC_BIT_OUT_DIS    9
`define AIOC_ERR_OVR1       0
`define AIOC_ERR_OVR2       1
`define AIOC_ERR_OUTSET     2
`define AIOC_ERR_NVM        4
`define AIOC_ERR_AVG        5
`define AIOC_ERR_HW         6
`define AIOC_ERR_COMM       7
`define AIOC_ERR_USED       16'h00F7
`define AIOC_AVG_MIN        16'h0001
`define AIOC_AVG_MAX        16'h0FFF
`define AIOC_OUT_MAX        16'h0FA0
`define AIOC_OVER_SCALE     12'hFF0
`define AIOC_CLK_MHZ        125
`define AIOC_IN_CONV_US     90
`define AIOC_OUT_CONV_US    50
`define AIOC_IN_CONV_CYC    (`AIOC_IN_CONV_US * `AIOC_CLK_MHZ)
`define AIOC_OUT_CONV_CYC   (`AIOC_OUT_CONV_US * `AIOC_CLK_MHZ)
`endif

// ### common/aioc_pkg.sv
// types shared by the analog control block
package aioc_pkg;
    typedef enum logic [1:0] {
        AIOC_IDLE = 2'b00,
        AIOC_IN1  = 2'b01,
        AIOC_IN2  = 2'b10,
        AIOC_OUT  = 2'b11
    } aioc_phase_type;

    typedef struct packed {
        logic in1_mode;
        logic in2_mode;
        logic out_mode;
        logic hold_cancel;
        logic in1_dis;
        logic in2_dis;
        logic out_dis;
    } aioc_ctrl_type;

    typedef struct packed {
        logic [7:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } aioc_bus_type;

    typedef struct packed {
        logic        sample_req;
        logic        sample_ch;
        logic        out_strobe;
        logic        out_current;
        logic        in1_current;
        logic        in2_current;
        logic [11:0] out_code;
    } aioc_conv_type;

    typedef struct packed {
        aioc_ctrl_type  ctrl;
        aioc_phase_type phase;
        logic [15:0]    timer;
        logic [15:0]    in1_value;
        logic [15:0]    in2_value;
        logic [15:0]    out_value;
        logic [15:0]    in1_avg;
        logic [15:0]    in2_avg;
        logic [15:0]    err;
        logic [15:0]    err_mask;
        logic [27:0]    acc1;
        logic [27:0]    acc2;
        logic [15:0]    cnt1;
        logic [15:0]    cnt2;
        logic [11:0]    held_code;
        logic [15:0]    rdata;
        logic           irq;
        logic           scan_s1;
        logic           scan_s2;
        logic           scan_s3;
        logic           run_s1;
        logic           run_s2;
        logic [3:0]     fault_s1;
        logic [3:0]     fault_s2;
        aioc_conv_type  conv;
        logic           pending;
    } aioc_state_type;
endpackage

// ### rtl/aioc_regs.sv
// analog input/output control and status register block
//
// Decided for this implementation: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "aioc_map.svh"

// How it works
// - ctrl bit: input 1 voltage/current mode
// - ctrl bit: input 2 voltage/current mode
// - ctrl bit: output voltage/current mode
// - on stop hold last, or offset
// - input 1 converted unless disabled
// - input 2 converted unless disabled
// - output driven unless disabled
// - error bits 0,1 flag over-scale
// - error bit 2 bad output; bit 3 unused
// - error bits 4,5: memory, averaging count
// - error bits 6,7: hardware, comm data
// - 90us per input, 50us per output
// - output codes 0..4000 map full scale
module aioc_regs #(
    parameter int          IN_CONV_CYC  = `AIOC_IN_CONV_CYC,
    parameter int          OUT_CONV_CYC = `AIOC_OUT_CONV_CYC,
    parameter logic [15:0] UNIT_ID      = 16'h00A5 // arbitrary value
) (
    input  wire logic                   core_clk,
    input  wire logic                   rst_n,
    input  wire logic [7:0]             reg_addr,
    input  wire logic [15:0]            reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output logic      [15:0]            reg_rdata,
    output logic                        irq,
    input  wire logic                   scan_tick,
    input  wire logic                   plc_run,
    input  wire logic [11:0]            adc_data,
    input  wire logic                   adc_valid,
    input  wire logic                   nvm_fault,
    input  wire logic                   hw_fault,
    input  wire logic                   comm_fault,
    input  wire logic                   ovr_fault,
    output aioc_pkg::aioc_conv_type     conv
);

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic avg_bad(input logic [15:0] n);
        avg_bad = (n < `AIOC_AVG_MIN) || (n > `AIOC_AVG_MAX);
    endfunction

    function automatic logic [15:0] cyc16(input int n);
        cyc16 = 16'(n - 1);
    endfunction

    // zero count is flagged already; dividing by one keeps data defined
    function automatic logic [15:0] avg_of(input logic [27:0] sum,
                                           input logic [15:0] n);
        avg_of = 16'(sum / ((n == 16'h0000) ? 28'h000_0001 : 28'(n)));
    endfunction

    aioc_pkg::aioc_state_type state;
    aioc_pkg::aioc_state_type next_state;
    aioc_pkg::aioc_bus_type   bus;

    assign bus.addr  = reg_addr;
    assign bus.wdata = reg_wdata;
    assign bus.wr    = reg_wr;
    assign bus.rd    = reg_rd;

    assign reg_rdata = state.rdata;
    assign irq       = state.irq;
    assign conv      = state.conv;

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        logic [15:0] ev;
        logic [15:0] clr;
        logic        scan_rise;
        logic        stopped;
        logic [11:0] drive;
        ev = 16'h0000;
        clr = 16'h0000;
        scan_rise = state.scan_s2 && !state.scan_s3;
        stopped = !state.run_s2;
        drive = 12'h000;
        next_state = state;
        // pins cross two flops before use
        next_state.scan_s1  = scan_tick;
        next_state.scan_s2  = state.scan_s1;
        next_state.scan_s3  = state.scan_s2;
        next_state.run_s1   = plc_run;
        next_state.run_s2   = state.run_s1;
        next_state.fault_s1 = {nvm_fault, hw_fault, comm_fault, ovr_fault};
        next_state.fault_s2 = state.fault_s1;
        next_state.conv.sample_req = 1'b0;
        next_state.conv.out_strobe = 1'b0;

        // register writes
        if (bus.wr) begin
            unique case (bus.addr)
                `AIOC_OFS_CTRL: begin
                    next_state.ctrl.in1_mode =
                        bus.wdata[`AIOC_BIT_IN1_MODE];
                    next_state.ctrl.in2_mode =
                        bus.wdata[`AIOC_BIT_IN2_MODE];
                    next_state.ctrl.out_mode =
                        bus.wdata[`AIOC_BIT_OUT_MODE];
                    next_state.ctrl.hold_cancel =
                        bus.wdata[`AIOC_BIT_HOLD_CAN];
                    next_state.ctrl.in1_dis =
                        bus.wdata[`AIOC_BIT_IN1_DIS];
                    next_state.ctrl.in2_dis =
                        bus.wdata[`AIOC_BIT_IN2_DIS];
                    next_state.ctrl.out_dis =
                        bus.wdata[`AIOC_BIT_OUT_DIS];
                end
                `AIOC_OFS_OUT_VALUE: next_state.out_value = bus.wdata;
                `AIOC_OFS_IN1_AVG:   next_state.in1_avg = bus.wdata;
                `AIOC_OFS_IN2_AVG:   next_state.in2_avg = bus.wdata;
                `AIOC_OFS_ERR:       clr = bus.wdata & `AIOC_ERR_USED;
                `AIOC_OFS_ERR_MASK:
                    next_state.err_mask = bus.wdata & `AIOC_ERR_USED;
                // id, input values and holes ignore writes
                default: ;
            endcase
        end

        // events from outside and from settings
        ev[`AIOC_ERR_NVM]  = state.fault_s2[3];
        ev[`AIOC_ERR_HW]   = state.fault_s2[2];
        ev[`AIOC_ERR_COMM] = state.fault_s2[1];
        // counts outside range flagged, not clamped
        ev[`AIOC_ERR_AVG] = (!state.ctrl.in1_dis && avg_bad(state.in1_avg))
            || (!state.ctrl.in2_dis && avg_bad(state.in2_avg));
        ev[`AIOC_ERR_OUTSET] = !state.ctrl.out_dis
            && (state.out_value > `AIOC_OUT_MAX);

        // ****************************************
        // conversion sequencer
        // ****************************************
        if (state.timer != 16'h0000) begin
            next_state.timer = state.timer - 16'h0001;
        end else begin
            unique case (state.phase)
                aioc_pkg::AIOC_IDLE: begin
                    if (scan_rise || state.pending) begin
                        next_state.pending = 1'b0;
                        next_state.phase = aioc_pkg::AIOC_IN1;
                        next_state.timer = 16'h0000;
                    end
                end
                aioc_pkg::AIOC_IN1: begin
                    next_state.phase = aioc_pkg::AIOC_IN2;
                    if (!state.ctrl.in1_dis) begin
                        next_state.conv.sample_req = 1'b1;
                        next_state.conv.sample_ch = 1'b0;
                        next_state.timer = cyc16(IN_CONV_CYC);
                    end
                end
                aioc_pkg::AIOC_IN2: begin
                    next_state.phase = aioc_pkg::AIOC_OUT;
                    if (!state.ctrl.in2_dis) begin
                        next_state.conv.sample_req = 1'b1;
                        next_state.conv.sample_ch = 1'b1;
                        next_state.timer = cyc16(IN_CONV_CYC);
                    end
                end
                aioc_pkg::AIOC_OUT: begin
                    next_state.phase = aioc_pkg::AIOC_IDLE;
                    if (!state.ctrl.out_dis) begin
                        next_state.conv.out_strobe = 1'b1;
                        next_state.timer = cyc16(OUT_CONV_CYC);
                    end
                end
            endcase
        end
        // a scan arriving mid-pass or in the output tail waits its turn
        if (scan_rise && (state.phase != aioc_pkg::AIOC_IDLE
            || state.timer != 16'h0000)) begin
            next_state.pending = 1'b1;
        end

        // ****************************************
        // averaging
        // ****************************************
        if (adc_valid && state.phase != aioc_pkg::AIOC_IDLE) begin
            if (!state.conv.sample_ch) begin
                ev[`AIOC_ERR_OVR1] = state.fault_s2[0]
                    || (adc_data >= `AIOC_OVER_SCALE);
                next_state.acc1 = state.acc1 + 28'(adc_data);
                next_state.cnt1 = state.cnt1 + 16'h0001;
                if (state.cnt1 + 16'h0001 >= state.in1_avg) begin
                    next_state.in1_value =
                        avg_of(next_state.acc1, state.in1_avg);
                    next_state.acc1 = 28'h000_0000;
                    next_state.cnt1 = 16'h0000;
                end
            end else begin
                ev[`AIOC_ERR_OVR2] = state.fault_s2[0]
                    || (adc_data >= `AIOC_OVER_SCALE);
                next_state.acc2 = state.acc2 + 28'(adc_data);
                next_state.cnt2 = state.cnt2 + 16'h0001;
                if (state.cnt2 + 16'h0001 >= state.in2_avg) begin
                    next_state.in2_value =
                        avg_of(next_state.acc2, state.in2_avg);
                    next_state.acc2 = 28'h000_0000;
                    next_state.cnt2 = 16'h0000;
                end
            end
        end

        // ****************************************
        // output drive
        // ****************************************
        // codes above full scale are clamped; bit 2 tells software
        drive = (state.out_value > `AIOC_OUT_MAX) ? 12'(`AIOC_OUT_MAX)
            : state.out_value[11:0];
        if (!stopped) begin
            next_state.held_code = drive;
        end
        if (stopped) begin
            next_state.conv.out_code = state.ctrl.hold_cancel
                ? 12'h000 : state.held_code;
        end else begin
            next_state.conv.out_code = drive;
        end
        next_state.conv.out_current = state.ctrl.out_mode;
        next_state.conv.in1_current = state.ctrl.in1_mode;
        next_state.conv.in2_current = state.ctrl.in2_mode;

        // ****************************************
        // status, mask, interrupt
        // ****************************************
        // set beats clear; bit 3 and top byte never set
        next_state.err = ((state.err & ~clr) | ev)
            & `AIOC_ERR_USED;
        next_state.irq = |(next_state.err & state.err_mask);

        // read data one cycle after strobe, zero otherwise
        next_state.rdata = 16'h0000;
        if (bus.rd) begin
            unique case (bus.addr)
                `AIOC_OFS_CTRL: begin
                    next_state.rdata[`AIOC_BIT_IN1_MODE] =
                        state.ctrl.in1_mode;
                    next_state.rdata[`AIOC_BIT_IN2_MODE] =
                        state.ctrl.in2_mode;
                    next_state.rdata[`AIOC_BIT_OUT_MODE] =
                        state.ctrl.out_mode;
                    next_state.rdata[`AIOC_BIT_HOLD_CAN] =
                        state.ctrl.hold_cancel;
                    next_state.rdata[`AIOC_BIT_IN1_DIS] = state.ctrl.in1_dis;
                    next_state.rdata[`AIOC_BIT_IN2_DIS] = state.ctrl.in2_dis;
                    next_state.rdata[`AIOC_BIT_OUT_DIS] = state.ctrl.out_dis;
                end
                `AIOC_OFS_IN1_VALUE: next_state.rdata = state.in1_value;
                `AIOC_OFS_IN2_VALUE: next_state.rdata = state.in2_value;
                `AIOC_OFS_OUT_VALUE: next_state.rdata = state.out_value;
                `AIOC_OFS_IN1_AVG:   next_state.rdata = state.in1_avg;
                `AIOC_OFS_IN2_AVG:   next_state.rdata = state.in2_avg;
                `AIOC_OFS_ERR:       next_state.rdata = state.err;
                `AIOC_OFS_ERR_MASK:  next_state.rdata = state.err_mask;
                `AIOC_OFS_ID:        next_state.rdata = UNIT_ID;
                default:             next_state.rdata = 16'h0000;
            endcase
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= '0;
            state.in1_avg <= `AIOC_AVG_MIN;
            state.in2_avg <= `AIOC_AVG_MIN;
        end else begin
            state <= next_state;
        end
    end

endmodule

// ### test/aioc_regs_checker.sv
// port assertions for the analog control register block
`timescale 1ns/1ps
// ****
// checker
// ****
module aioc_regs_checker #(
    parameter logic [15:0] UNIT_ID = 16'h0000
) (
    input wire logic                    core_clk,
    input wire logic                    rst_n,
    input wire logic [7:0]              reg_addr,
    input wire logic [15:0]             reg_wdata,
    input wire logic                    reg_wr,
    input wire logic                    reg_rd,
    input wire logic [15:0]             reg_rdata,
    input wire logic                    irq,
    input wire aioc_pkg::aioc_conv_type conv
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    a_rdata_idle: assert property (
        !$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data outside read slot");
    a_id_read: assert property (
        reg_rd && reg_addr == 8'h08 |=> reg_rdata == UNIT_ID)
        else $error("id register wrong");
    a_stray_read: assert property (
        reg_rd && reg_addr > 8'h09 |=> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    a_in1_mode: assert property (
        reg_wr && reg_addr == 8'h00 ##1 (!reg_wr) [*3]
        |-> conv.in1_current == $past(reg_wdata[0], 3))
        else $error("input 1 mode not applied");
    a_in2_mode: assert property (
        reg_wr && reg_addr == 8'h00 ##1 (!reg_wr) [*3]
        |-> conv.in2_current == $past(reg_wdata[1], 3))
        else $error("input 2 mode not applied");
    a_out_mode: assert property (
        reg_wr && reg_addr == 8'h00 ##1 (!reg_wr) [*3]
        |-> conv.out_current == $past(reg_wdata[2], 3))
        else $error("output mode not applied");
    a_code_limit: assert property (
        conv.out_code <= 12'hFA0)
        else $error("output code above full scale");
    a_req_gap: assert property (
        conv.sample_req |=> (!conv.sample_req) [*3])
        else $error("sample requests too close");
    a_irq_masked: assert property (
        reg_wr && reg_addr == 8'h07 && reg_wdata == 16'h0000 |-> ##2 !irq)
        else $error("interrupt high with mask clear");
endmodule

bind aioc_regs aioc_regs_checker #(.UNIT_ID(UNIT_ID)) u_chk (
    .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq), .conv(conv));

// ### test/aioc_adc_model.sv
// converter channel model answering sample requests
`timescale 1ns/1ps
// ****
// model
// ****
module aioc_adc_model (
    input  wire logic                    core_clk,
    input  wire logic                    rst_n,
    input  wire aioc_pkg::aioc_conv_type conv,
    input  wire logic                    slow,
    input  wire logic [11:0]             code1,
    input  wire logic [11:0]             code2,
    output logic      [11:0]             adc_data,
    output logic                         adc_valid
);
    logic busy;
    logic ch;
    logic lag;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            busy      <= 1'b0;
            ch        <= 1'b0;
            lag       <= 1'b0;
            adc_valid <= 1'b0;
            adc_data  <= 12'h000;
        end else begin
            adc_valid <= 1'b0;
            // released bus toggles so stale data never looks valid
            adc_data  <= ~adc_data;
            if (conv.sample_req) begin
                busy <= 1'b1;
                // only the requested channel answers
                ch   <= conv.sample_ch;
                lag  <= slow;
            end else if (busy && lag) begin
                lag <= 1'b0;
            end else if (busy) begin
                // answer lands inside the conversion slot
                busy      <= 1'b0;
                adc_valid <= 1'b1;
                adc_data  <= ch ? code2 : code1;
            end
        end
    end
endmodule

// ### test/test_analog_io_control_status_regs.sv
// register level tests of the analog control block
`timescale 1ns/1ps
// ****
// testbench
// ****
module test_analog_io_control_status_regs;
    localparam logic [15:0] ID = 16'h005A; // arbitrary value
    logic                    core_clk;
    logic                    rst_n;
    logic [7:0]              reg_addr;
    logic [15:0]             reg_wdata;
    logic                    reg_wr;
    logic                    reg_rd;
    logic [15:0]             reg_rdata;
    logic                    irq;
    logic                    scan_tick;
    logic                    plc_run;
    logic [11:0]             adc_data;
    logic                    adc_valid;
    logic [3:0]              flt;
    logic                    slow;
    logic [11:0]             code1;
    logic [11:0]             code2;
    aioc_pkg::aioc_conv_type conv;
    int                      error_cnt;
    int                      checks_done;
    int                      cycles;
    int                      reqs;
    int                      strobes;
    int                      n;
    int                      m;
    logic [15:0] cnt_tab [4] = '{16'h0000, 16'h0FFF, 16'h1000, 16'h0001};
    logic [15:0] avg_err [4] = '{16'h0020, 16'h0000, 16'h0020, 16'h0000};
    logic [15:0] flt_err [3] = '{16'h0010, 16'h0040, 16'h0080};

    aioc_regs #(.IN_CONV_CYC(4), .OUT_CONV_CYC(2), .UNIT_ID(ID)) DUT (
        .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .irq(irq), .scan_tick(scan_tick),
        .plc_run(plc_run), .adc_data(adc_data), .adc_valid(adc_valid),
        .nvm_fault(flt[0]), .hw_fault(flt[1]), .comm_fault(flt[2]),
        .ovr_fault(flt[3]), .conv(conv));
    aioc_adc_model u_adc (
        .core_clk(core_clk), .rst_n(rst_n), .conv(conv), .slow(slow),
        .code1(code1), .code2(code2), .adc_data(adc_data),
        .adc_valid(adc_valid));

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles++;
        if (conv.sample_req === 1'b1) reqs++;
        if (conv.out_strobe === 1'b1) strobes++;
        if (cycles == 20000) begin
            error_cnt++;
            wrap_up();
        end
    end
    task automatic wrap_up();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [15:0] exp,
                      input string what);
        @(posedge core_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 check(what, reg_rdata, exp);
    endtask
    // no done flag: wait covers sync plus a full pass
    task automatic scan();
        @(posedge core_clk);
        scan_tick <= 1'b1;
        repeat (4) @(posedge core_clk);
        scan_tick <= 1'b0;
        repeat (30) @(posedge core_clk);
    endtask

    initial begin
        rst_n = 1'b0;
        {reg_addr, reg_wdata, reg_wr, reg_rd, scan_tick, flt} = '0;
        {plc_run, slow, code1, code2} = {1'b1, 1'b0, 24'h1234_56};
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(8'h00, 16'h0000, "ctrl_rst");
        rd(8'h04, 16'h0001, "avg1_rst");
        rd(8'h05, 16'h0001, "avg2_rst");
        rd(8'h06, 16'h0000, "err_rst");
        rd(8'h08, ID, "id");
        wr(8'h00, 16'h03C7);
        rd(8'h00, 16'h03C7, "ctrl");
        check("modes", {13'h0000, conv.in1_current, conv.in2_current,
              conv.out_current}, 16'h0007);
        wr(8'h00, 16'h0000);
        wr(8'h01, 16'hFFFF);
        wr(8'h02, 16'hFFFF);
        wr(8'h08, 16'hFFFF);
        rd(8'h01, 16'h0000, "in1_ro");
        rd(8'h02, 16'h0000, "in2_ro");
        rd(8'h08, ID, "id_ro");
        rd(8'h20, 16'h0000, "unmapped");
        wr(8'h07, 16'hFFFF);
        rd(8'h07, 16'h00F7, "mask_used");
        wr(8'h07, 16'h0004);
        wr(8'h03, 16'h0FA1);
        repeat (2) @(posedge core_clk);
        rd(8'h06, 16'h0004, "err_out");
        check("irq_on", {15'h0000, irq}, 16'h0001);
        wr(8'h07, 16'h0000);
        repeat (2) @(posedge core_clk);
        #1 check("irq_mask", {15'h0000, irq}, 16'h0000);
        wr(8'h03, 16'h0FA0);
        wr(8'h06, 16'hFFFF);
        rd(8'h06, 16'h0000, "err_clr");
        rd(8'h03, 16'h0FA0, "out_value");
        foreach (cnt_tab[i]) begin
            wr(8'h04, cnt_tab[i]);
            wr(8'h06, 16'hFFFF);
            repeat (2) @(posedge core_clk);
            rd(8'h06, avg_err[i], "err_avg");
        end
        for (int i = 0; i < 3; i++) begin
            flt <= 4'b0001 << i;
            repeat (4) @(posedge core_clk);
            flt <= 4'b0000;
            repeat (4) @(posedge core_clk);
            rd(8'h06, flt_err[i], "err_fault");
            wr(8'h06, 16'hFFFF);
        end
        n = reqs;
        m = strobes;
        scan();
        rd(8'h01, 16'h0123, "in1");
        rd(8'h02, 16'h0456, "in2");
        check("reqs", 16'(reqs - n), 16'h0002);
        check("strobes", 16'(strobes - m), 16'h0001);
        check("code", {4'h0, conv.out_code}, 16'h0FA0);
        {slow, code1, code2} <= {1'b1, 24'hFF5_111};
        wr(8'h00, 16'h0300);
        wr(8'h06, 16'hFFFF);
        n = reqs;
        m = strobes;
        scan();
        rd(8'h02, 16'h0456, "in2_kept");
        rd(8'h06, 16'h0001, "err_ovr1");
        check("reqs_1", 16'(reqs - n), 16'h0001);
        check("strobes_0", 16'(strobes - m), 16'h0000);
        {slow, code2} <= {1'b0, 12'hFF0};
        wr(8'h00, 16'h0080);
        wr(8'h06, 16'hFFFF);
        scan();
        rd(8'h06, 16'h0002, "err_ovr2");
        rd(8'h01, 16'h0FF5, "in1_kept");
        // codes in range; the over-scale pin alone flags both inputs
        {code1, code2, flt} <= {24'h100_200, 4'b1000};
        wr(8'h04, 16'h0002);
        wr(8'h00, 16'h0000);
        wr(8'h03, 16'h0200);
        wr(8'h06, 16'hFFFF);
        scan();
        rd(8'h06, 16'h0003, "err_ovr_pin");
        rd(8'h01, 16'h0FF5, "avg_half");
        check("code_run", {4'h0, conv.out_code}, 16'h0200);
        {code1, flt} <= {12'h300, 4'b0000};
        plc_run <= 1'b0;
        // let the stop settle so the later write is the one ignored
        repeat (4) @(posedge core_clk);
        wr(8'h03, 16'h0300);
        scan();
        rd(8'h01, 16'h0200, "avg_two");
        check("hold", {4'h0, conv.out_code}, 16'h0200);
        wr(8'h00, 16'h0040);
        scan();
        #1 check("offset", {4'h0, conv.out_code}, 16'h0000);
        wrap_up();
    end
endmodule
